//--- verilog/i2ccs_pkg.sv
// Constants, states and carrier types of the I2C controller sequencer
package i2ccs_pkg;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [1:0] PH_LOW = 2'h0;
    localparam logic [1:0] PH_RISE = 2'h1;
    localparam logic [1:0] PH_HIGH = 2'h2;
    localparam logic [1:0] PH_HOLD = 2'h3;
    localparam logic [8:0] RX_FULL_CNT = 9'h100;
    localparam logic [1:0] ADDR_TWO = 2'h2;
    localparam logic [1:0] ADDR_ONE = 2'h1;
    localparam logic [3:0] IDLE_HOLD_CYC = 4'hF;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam int EV_CLR_SS = 0;
    localparam int EV_CLR_RS = 1;
    localparam int EV_ACK = 2;
    localparam int EV_DONE = 3;
    localparam int EV_RX = 4;
    localparam int EV_TXACK = 5;
    localparam int EV_N = 6;
    localparam logic [EV_N-1:0] EV_RST = 6'h00;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_START = 6'h02,
        ST_NEXT = 6'h04,
        ST_BYTE = 6'h08,
        ST_RESTART = 6'h10,
        ST_STOP = 6'h20
    } i2ccs_state_t;
    typedef struct packed {
        logic en;
        logic ten;
        logic [7:0] cnt;
        logic [7:0] hi;
        logic [7:0] lo;
        logic start;
        logic restart;
        logic stop;
    } i2ccs_cfg_t;
    localparam i2ccs_cfg_t CFG_RST = 29'h0000_0000;
endpackage : i2ccs_pkg

//--- verilog/i2ccs_seq.sv
// I2C controller-mode sequencer: request bits, address, receive and transmit
//
// Behaviour
// RULE_01: After START the first byte shifted out is the address byte from transmit word.
// RULE_02: Software avoids reserved address codes as ordinary targets.
// RULE_03: Seven-bit mode: one address byte, MSB first, R/W last.
// RULE_04: Ten-bit mode: prefix with R/W 0, then second address byte, then data.
// RULE_05: Ten-bit read: repeated START, prefix again with R/W 1, then receive.
// RULE_06: Enabled start request makes START, delayed while the bus is busy.
// RULE_07: Restart request finishes the transfer, repeats START; bit clears as it begins.
// RULE_08: Start bit clears only after STOP sent; stop request makes STOP.
// RULE_09: Start with restart: START first, RESTART at end of that transaction.
// RULE_10: Restart with stop: RESTART wins, then both bits clear.
// RULE_11: All three set: START, then RESTART; stop cleared without effect.
// RULE_12: Controller enable low holds all three request bits at zero.
// RULE_13: Software changes mode, counts and select only while idle.
// RULE_14: Flags, data port and request bits may be written any time.
// RULE_15: Receive setup: byte count, address with R/W 1, then start.
// RULE_16: Target ACK of the address byte sets the address-acknowledged flag.
// RULE_17: Each received byte is handed to software; all but the last are ACKed.
// RULE_18: Last programmed byte is NACKed and the done flag set.
// RULE_19: After a receive, restart request gives RESTART, stop request gives STOP.
// RULE_20: Transmit setup: address with R/W 0, preload data, then start.
// RULE_21: Empty transmit word pauses at byte start until data or request.
// RULE_22: All bytes sent and empty: done flag, then RESTART or STOP.
// RULE_23: SCL high and low each last programmed count plus one link clocks.
`timescale 1ns/100ps
`default_nettype none
module i2ccs_seq (
    // Clocks and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic link_clk,
    // Configuration
    input wire logic controller_enable,
    input wire logic ten_bit_select,
    input wire logic [7:0] receive_byte_count,
    input wire logic [7:0] scl_high_count,
    input wire logic [7:0] scl_low_count,
    // Request bits
    input wire logic start_set,
    input wire logic restart_set,
    input wire logic stop_set,
    output logic start_req_r,
    output logic restart_req_r,
    output logic stop_req_r,
    // Transmit word
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready_r,
    // Receive word
    output logic [7:0] rx_data_r,
    output logic rx_valid_r,
    // Flags
    input wire logic addr_ack_clr,
    input wire logic done_clr,
    output logic addr_ack_flag_r,
    output logic done_flag_r,
    // Bus pins
    input wire logic scl_in,
    output logic scl_o_r,
    output logic scl_oe_n_r,
    input wire logic sda_in,
    output logic sda_o_r,
    output logic sda_oe_n_r
);
    i2ccs_pkg::i2ccs_cfg_t cfg_sys;
    i2ccs_pkg::i2ccs_cfg_t cfg_s1_r;
    i2ccs_pkg::i2ccs_cfg_t cfg;
    logic [i2ccs_pkg::EV_N-1:0] lk_tgl_r;
    logic [i2ccs_pkg::EV_N-1:0] ev_s1_r;
    logic [i2ccs_pkg::EV_N-1:0] ev_s2_r;
    logic [i2ccs_pkg::EV_N-1:0] ev_s3_r;
    logic [i2ccs_pkg::EV_N-1:0] ev;
    logic tx_tgl_r;
    logic [7:0] tx_word_r;
    logic tx_push;
    logic lk_rst_s1_r;
    logic lk_rst_r;
    logic txq_s1_r;
    logic txq_s2_r;
    logic tx_avail;
    logic [1:0] pin_s1_r;
    logic [1:0] pin_s2_r;
    logic sda_prev_r;
    logic scl_s;
    logic sda_s;
    logic bus_busy_r;
    i2ccs_pkg::i2ccs_state_t st_r;
    logic [1:0] ph_r;
    logic [7:0] tim_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic [7:0] rx_byte_r;
    logic rw_r;
    logic rx_mode_r;
    logic addr_next_r;
    logic [1:0] addr_cnt_r;
    logic [8:0] rx_left_r;
    logic [3:0] hold_r;
    logic drive_low;

    // System domain: request bits, set wins over a hardware clear
    assign ev = ev_s2_r ^ ev_s3_r;
    always_ff @(posedge sys_clk) begin
        if (rst || !controller_enable) begin // RULE_12
            start_req_r <= 1'b0;
            restart_req_r <= 1'b0;
            stop_req_r <= 1'b0;
        end else begin
            start_req_r <= start_set | (start_req_r & ~ev[i2ccs_pkg::EV_CLR_SS]); // RULE_08 RULE_14
            restart_req_r <= restart_set | (restart_req_r & ~ev[i2ccs_pkg::EV_CLR_RS]); // RULE_07
            stop_req_r <= stop_set | (stop_req_r & ~ev[i2ccs_pkg::EV_CLR_SS]
                & ~ev[i2ccs_pkg::EV_CLR_RS]); // RULE_10 RULE_11
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ev_s1_r <= i2ccs_pkg::EV_RST;
            ev_s2_r <= i2ccs_pkg::EV_RST;
            ev_s3_r <= i2ccs_pkg::EV_RST;
        end else begin
            ev_s1_r <= lk_tgl_r;
            ev_s2_r <= ev_s1_r;
            ev_s3_r <= ev_s2_r;
        end
    end

    // One-word transmit holding register, toggle handshake to the link side
    assign tx_push = tx_valid & tx_ready_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_tgl_r <= 1'b0;
            tx_word_r <= i2ccs_pkg::BYTE_RST;
            tx_ready_r <= 1'b0;
        end else begin
            tx_tgl_r <= tx_tgl_r ^ tx_push;
            if (tx_push) begin
                tx_word_r <= tx_data;
            end
            tx_ready_r <= ((tx_tgl_r ^ tx_push) == ev_s2_r[i2ccs_pkg::EV_TXACK]); // RULE_14
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_data_r <= i2ccs_pkg::BYTE_RST;
            rx_valid_r <= 1'b0;
            addr_ack_flag_r <= 1'b0;
            done_flag_r <= 1'b0;
        end else begin
            rx_valid_r <= ev[i2ccs_pkg::EV_RX]; // RULE_17
            if (ev[i2ccs_pkg::EV_RX]) begin
                rx_data_r <= rx_byte_r;
            end
            addr_ack_flag_r <= ev[i2ccs_pkg::EV_ACK] | (addr_ack_flag_r & ~addr_ack_clr); // RULE_16
            done_flag_r <= ev[i2ccs_pkg::EV_DONE] | (done_flag_r & ~done_clr); // RULE_18 RULE_22
        end
    end

    // Config is quasi-static while idle, so a plain two-stage capture suffices
    always_comb begin
        cfg_sys = i2ccs_pkg::CFG_RST;
        cfg_sys.en = controller_enable;
        cfg_sys.ten = ten_bit_select;
        cfg_sys.cnt = receive_byte_count;
        cfg_sys.hi = scl_high_count;
        cfg_sys.lo = scl_low_count;
        cfg_sys.start = start_req_r;
        cfg_sys.restart = restart_req_r;
        cfg_sys.stop = stop_req_r;
    end

    // Link domain: reset, config and request bits, transmit toggle and pin synchronisers
    always_ff @(posedge link_clk) begin
        lk_rst_s1_r <= rst;
        lk_rst_r <= lk_rst_s1_r;
    end

    always_ff @(posedge link_clk) begin
        if (lk_rst_r) begin
            cfg_s1_r <= i2ccs_pkg::CFG_RST;
            cfg <= i2ccs_pkg::CFG_RST;
            txq_s1_r <= 1'b0;
            txq_s2_r <= 1'b0;
            pin_s1_r <= 2'h3;
            pin_s2_r <= 2'h3;
            sda_prev_r <= 1'b1;
        end else begin
            cfg_s1_r <= cfg_sys;
            cfg <= cfg_s1_r;
            txq_s1_r <= tx_tgl_r;
            txq_s2_r <= txq_s1_r;
            pin_s1_r <= {scl_in, sda_in};
            pin_s2_r <= pin_s1_r;
            sda_prev_r <= pin_s2_r[0];
        end
    end
    assign scl_s = pin_s2_r[1];
    assign sda_s = pin_s2_r[0];
    assign tx_avail = txq_s2_r ^ lk_tgl_r[i2ccs_pkg::EV_TXACK];

    // START and STOP seen on the wire, including our own
    always_ff @(posedge link_clk) begin
        if (lk_rst_r) begin
            bus_busy_r <= 1'b0;
        end else if (scl_s && sda_prev_r && !sda_s) begin
            bus_busy_r <= 1'b1;
        end else if (scl_s && !sda_prev_r && sda_s) begin
            bus_busy_r <= 1'b0;
        end
    end

    // Open-drain: output level stays low, only the enable moves
    always_ff @(posedge link_clk) begin
        scl_o_r <= 1'b0;
        sda_o_r <= 1'b0;
    end

    // Data bit or acknowledge slot that pulls SDA low
    assign drive_low = (bit_r == i2ccs_pkg::ACK_BIT) ? (rx_mode_r && rx_left_r != 9'h001)
        : (!rx_mode_r && !sh_r[7]); // RULE_03 RULE_17 RULE_18

    always_ff @(posedge link_clk) begin
        if (lk_rst_r) begin
            st_r <= i2ccs_pkg::ST_IDLE;
            ph_r <= i2ccs_pkg::PH_LOW;
            tim_r <= 8'h00;
            bit_r <= 4'h0;
            sh_r <= i2ccs_pkg::BYTE_RST;
            rx_byte_r <= i2ccs_pkg::BYTE_RST;
            rw_r <= 1'b0;
            rx_mode_r <= 1'b0;
            addr_next_r <= 1'b0;
            addr_cnt_r <= 2'h0;
            rx_left_r <= 9'h000;
            hold_r <= 4'h0;
            lk_tgl_r <= i2ccs_pkg::EV_RST;
            scl_oe_n_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
        end else begin
            if (tim_r != 8'h00) begin
                tim_r <= tim_r - 8'h01;
            end
            case (st_r)
                i2ccs_pkg::ST_IDLE: begin
                    scl_oe_n_r <= 1'b1;
                    sda_oe_n_r <= 1'b1;
                    rx_mode_r <= 1'b0;
                    if (hold_r != 4'h0) begin
                        hold_r <= hold_r - 4'h1;
                    end else if (cfg.en && cfg.start && !bus_busy_r) begin // RULE_06 RULE_09
                        st_r <= i2ccs_pkg::ST_START;
                        sda_oe_n_r <= 1'b0;
                        tim_r <= cfg.hi;
                    end
                end
                i2ccs_pkg::ST_START: begin
                    if (tim_r == 8'h00) begin
                        scl_oe_n_r <= 1'b0;
                        addr_next_r <= 1'b1;
                        st_r <= i2ccs_pkg::ST_NEXT;
                    end
                end
                i2ccs_pkg::ST_NEXT: begin
                    if (!cfg.en) begin
                        st_r <= i2ccs_pkg::ST_IDLE;
                    end else if (rx_mode_r && rx_left_r != 9'h000) begin
                        st_r <= i2ccs_pkg::ST_BYTE;
                        ph_r <= i2ccs_pkg::PH_LOW;
                        tim_r <= cfg.lo;
                        bit_r <= 4'h0;
                    end else if (!rx_mode_r && tx_avail) begin // RULE_01 RULE_21
                        sh_r <= tx_word_r;
                        lk_tgl_r[i2ccs_pkg::EV_TXACK] <= ~lk_tgl_r[i2ccs_pkg::EV_TXACK];
                        if (addr_next_r) begin
                            addr_next_r <= 1'b0;
                            rw_r <= tx_word_r[0];
                            addr_cnt_r <= (cfg.ten && !tx_word_r[0])
                                ? i2ccs_pkg::ADDR_TWO : i2ccs_pkg::ADDR_ONE; // RULE_04 RULE_05
                        end
                        st_r <= i2ccs_pkg::ST_BYTE;
                        ph_r <= i2ccs_pkg::PH_LOW;
                        tim_r <= cfg.lo;
                        bit_r <= 4'h0;
                    end else if (cfg.restart) begin // RULE_07 RULE_10 RULE_19 RULE_22
                        if (!rx_mode_r) begin
                            lk_tgl_r[i2ccs_pkg::EV_DONE] <= ~lk_tgl_r[i2ccs_pkg::EV_DONE];
                        end
                        lk_tgl_r[i2ccs_pkg::EV_CLR_RS] <= ~lk_tgl_r[i2ccs_pkg::EV_CLR_RS];
                        rx_mode_r <= 1'b0;
                        sda_oe_n_r <= 1'b1;
                        st_r <= i2ccs_pkg::ST_RESTART;
                        ph_r <= i2ccs_pkg::PH_LOW;
                        tim_r <= cfg.lo;
                    end else if (cfg.stop) begin // RULE_08 RULE_19 RULE_22
                        if (!rx_mode_r) begin
                            lk_tgl_r[i2ccs_pkg::EV_DONE] <= ~lk_tgl_r[i2ccs_pkg::EV_DONE];
                        end
                        sda_oe_n_r <= 1'b0;
                        st_r <= i2ccs_pkg::ST_STOP;
                        ph_r <= i2ccs_pkg::PH_LOW;
                        tim_r <= cfg.lo;
                    end
                    // Otherwise SCL stays low: the pause of an empty transmit word
                end
                i2ccs_pkg::ST_BYTE: begin
                    case (ph_r)
                        i2ccs_pkg::PH_LOW: begin
                            sda_oe_n_r <= ~drive_low;
                            if (tim_r == 8'h00) begin // RULE_23
                                scl_oe_n_r <= 1'b1;
                                ph_r <= i2ccs_pkg::PH_RISE;
                            end
                        end
                        i2ccs_pkg::PH_RISE: begin
                            // High time counts only once SCL is really high
                            if (scl_s) begin
                                tim_r <= cfg.hi;
                                ph_r <= i2ccs_pkg::PH_HIGH;
                            end
                        end
                        i2ccs_pkg::PH_HIGH: begin
                            if (tim_r == 8'h00) begin // RULE_23
                                scl_oe_n_r <= 1'b0;
                                ph_r <= i2ccs_pkg::PH_LOW;
                                tim_r <= cfg.lo;
                                if (bit_r != i2ccs_pkg::ACK_BIT) begin
                                    sh_r <= {sh_r[6:0], sda_s}; // RULE_03
                                    bit_r <= bit_r + 4'h1;
                                end else begin
                                    st_r <= i2ccs_pkg::ST_NEXT;
                                    if (rx_mode_r) begin // RULE_17 RULE_18
                                        rx_byte_r <= sh_r;
                                        lk_tgl_r[i2ccs_pkg::EV_RX] <= ~lk_tgl_r[i2ccs_pkg::EV_RX];
                                        rx_left_r <= rx_left_r - 9'h001;
                                        if (rx_left_r == 9'h001) begin
                                            lk_tgl_r[i2ccs_pkg::EV_DONE] <=
                                                ~lk_tgl_r[i2ccs_pkg::EV_DONE];
                                        end
                                    end
                                    if (addr_cnt_r != 2'h0) begin
                                        addr_cnt_r <= addr_cnt_r - 2'h1;
                                        if (addr_cnt_r == i2ccs_pkg::ADDR_ONE) begin
                                            if (!sda_s) begin // RULE_16
                                                lk_tgl_r[i2ccs_pkg::EV_ACK] <=
                                                    ~lk_tgl_r[i2ccs_pkg::EV_ACK];
                                            end
                                            rx_mode_r <= rw_r; // RULE_05
                                            rx_left_r <= (cfg.cnt == 8'h00)
                                                ? i2ccs_pkg::RX_FULL_CNT : {1'b0, cfg.cnt};
                                        end
                                    end
                                end
                            end
                        end
                        default: begin
                            ph_r <= i2ccs_pkg::PH_LOW;
                        end
                    endcase
                end
                i2ccs_pkg::ST_RESTART, i2ccs_pkg::ST_STOP: begin
                    case (ph_r)
                        i2ccs_pkg::PH_LOW: begin
                            if (tim_r == 8'h00) begin
                                scl_oe_n_r <= 1'b1;
                                ph_r <= i2ccs_pkg::PH_RISE;
                            end
                        end
                        i2ccs_pkg::PH_RISE: begin
                            if (scl_s) begin
                                tim_r <= cfg.hi;
                                ph_r <= i2ccs_pkg::PH_HIGH;
                            end
                        end
                        i2ccs_pkg::PH_HIGH: begin
                            if (tim_r == 8'h00) begin
                                sda_oe_n_r <= (st_r == i2ccs_pkg::ST_STOP);
                                tim_r <= cfg.hi;
                                ph_r <= i2ccs_pkg::PH_HOLD;
                            end
                        end
                        default: begin
                            if (tim_r == 8'h00) begin
                                ph_r <= i2ccs_pkg::PH_LOW;
                                if (st_r == i2ccs_pkg::ST_STOP) begin // RULE_08
                                    lk_tgl_r[i2ccs_pkg::EV_CLR_SS] <=
                                        ~lk_tgl_r[i2ccs_pkg::EV_CLR_SS];
                                    // Wait until the cleared start bit is seen here
                                    hold_r <= i2ccs_pkg::IDLE_HOLD_CYC;
                                    st_r <= i2ccs_pkg::ST_IDLE;
                                end else begin
                                    scl_oe_n_r <= 1'b0;
                                    addr_next_r <= 1'b1;
                                    st_r <= i2ccs_pkg::ST_NEXT;
                                end
                            end
                        end
                    endcase
                end
                default: begin
                    st_r <= i2ccs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    property p_en_clears;
        @(posedge sys_clk) disable iff (rst)
        !controller_enable |=> !start_req_r && !restart_req_r && !stop_req_r;
    endproperty
    a_en_clears: assert property (p_en_clears) else $error("request bit set while disabled"); // RULE_12

    property p_ack_flag;
        @(posedge sys_clk) disable iff (rst)
        ev[i2ccs_pkg::EV_ACK] |=> addr_ack_flag_r;
    endproperty
    a_ack_flag: assert property (p_ack_flag) else $error("address ack flag not set"); // RULE_16

    property p_done_flag;
        @(posedge sys_clk) disable iff (rst)
        ev[i2ccs_pkg::EV_DONE] |=> done_flag_r ##1 (done_flag_r || $past(done_clr));
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag lost"); // RULE_18

    property p_busy_wait;
        @(posedge link_clk) disable iff (lk_rst_r)
        (st_r == i2ccs_pkg::ST_IDLE) && bus_busy_r |=> st_r == i2ccs_pkg::ST_IDLE;
    endproperty
    a_busy_wait: assert property (p_busy_wait) else $error("START on a busy bus"); // RULE_06

    property p_restart_wins;
        @(posedge link_clk) disable iff (lk_rst_r)
        (st_r == i2ccs_pkg::ST_NEXT) && cfg.en && cfg.restart && cfg.stop && !tx_avail
            && !(rx_mode_r && rx_left_r != 9'h000) |=> st_r == i2ccs_pkg::ST_RESTART;
    endproperty
    a_restart_wins: assert property (p_restart_wins) else $error("STOP chosen over RESTART"); // RULE_10

    property p_pause;
        @(posedge link_clk) disable iff (lk_rst_r)
        (st_r == i2ccs_pkg::ST_NEXT) && cfg.en && !rx_mode_r && !tx_avail && !cfg.restart
            && !cfg.stop |=> (st_r == i2ccs_pkg::ST_NEXT) && !scl_oe_n_r;
    endproperty
    a_pause: assert property (p_pause) else $error("no pause on empty transmit word"); // RULE_21

    property p_addr_load;
        @(posedge link_clk) disable iff (lk_rst_r)
        (st_r == i2ccs_pkg::ST_NEXT) && cfg.en && addr_next_r && tx_avail
            && !rx_mode_r |=> (st_r == i2ccs_pkg::ST_BYTE) && sh_r == $past(tx_word_r);
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address byte not loaded"); // RULE_01

    property p_sda_stable;
        @(posedge link_clk) disable iff (lk_rst_r)
        (st_r == i2ccs_pkg::ST_BYTE) && (ph_r == i2ccs_pkg::PH_HIGH) |=> $stable(sda_oe_n_r);
    endproperty
    a_sda_stable: assert property (p_sda_stable) else $error("SDA moved while SCL high"); // RULE_03

    property p_rx_ack;
        @(posedge link_clk) disable iff (lk_rst_r)
        (st_r == i2ccs_pkg::ST_BYTE) && (ph_r == i2ccs_pkg::PH_LOW) && rx_mode_r
            && (bit_r == i2ccs_pkg::ACK_BIT) |=> sda_oe_n_r == (rx_left_r == 9'h001);
    endproperty
    a_rx_ack: assert property (p_rx_ack) else $error("wrong ACK or NACK on receive"); // RULE_17

    property p_low_len;
        @(posedge link_clk) disable iff (lk_rst_r)
        (st_r == i2ccs_pkg::ST_BYTE) && (ph_r == i2ccs_pkg::PH_LOW) && tim_r != 8'h00
            |=> !scl_oe_n_r;
    endproperty
    a_low_len: assert property (p_low_len) else $error("SCL low phase cut short"); // RULE_23

    c_start: cover property (@(posedge link_clk) st_r == i2ccs_pkg::ST_START);
    c_restart: cover property (@(posedge link_clk) st_r == i2ccs_pkg::ST_RESTART);
    c_stop: cover property (@(posedge link_clk) st_r == i2ccs_pkg::ST_STOP);
    c_rx_done: cover property (@(posedge sys_clk) rx_valid_r && done_flag_r);
endmodule : i2ccs_seq
`default_nettype wire

//--- sim/i2ccs_target.sv
// Behavioural I2C target for the sequencer bench
`timescale 1ns/100ps
`default_nettype none
module i2ccs_target #(
    parameter logic [7:0] RD_BYTE = 8'h96
) (
    // Bus
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe_n
);
    int n = 9;
    logic adr = 1'b0;
    logic rd = 1'b0;
    logic busy = 1'b0;
    logic [7:0] sh = 8'h00;
    logic [7:0] got = 8'h00;
    logic [7:0] nbytes = 8'h00;
    logic [7:0] starts = 8'h00;
    logic [7:0] stops = 8'h00;
    initial sda_oe_n = 1'b1;
    always @(negedge sda) if (scl === 1'b1) begin
        n = 0;
        adr = 1'b1;
        rd = 1'b0;
        busy = 1'b1;
        starts++;
    end
    // Lines leaving reset rise together: not a STOP
    always @(posedge sda) if (scl === 1'b1 && busy) begin
        stops++;
        busy = 1'b0;
    end
    always @(posedge scl) begin
        if (n < 8) sh = {sh[6:0], sda};
        if (n == 8 && rd && sda) rd = 1'b0;
        n++;
    end
    always @(negedge scl) begin
        if (n == 8) begin
            got = sh;
            nbytes++;
            sda_oe_n = rd;
            if (adr) rd = sh[0];
            adr = 1'b0;
        end else begin
            if (n >= 9) n = 0;
            // Released level is the pull-up, not a held value
            sda_oe_n = (rd && n < 8) ? RD_BYTE[7 - n] : 1'b1;
        end
    end
endmodule : i2ccs_target
`default_nettype wire

//--- sim/i2ccs_seq_test.sv
// Self-checking bench for the I2C controller sequencer
`timescale 1ns/100ps
`default_nettype none
module i2ccs_seq_test;
    logic sys_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, en = 1'b0, ten = 1'b0;
    logic ss = 1'b0, rs = 1'b0, ps = 1'b0, ac = 1'b0, dc = 1'b0, tx_valid = 1'b0;
    logic [7:0] cnt = 8'h01, tx_data = 8'h00, rx_data;
    logic start_r, restart_r, stop_r, tx_ready, rx_valid, aflag, dflag, scl_oe_n, sda_oe_n, t_oe_n;
    logic scl_o, sda_o;
    wire scl = scl_oe_n;
    wire sda = sda_oe_n & t_oe_n;
    int failures = 0, checks = 0, cyc = 0, nrx = 0;
    always #5 sys_clk = ~sys_clk;
    always #7.5 link_clk = ~link_clk;
    i2ccs_seq u_i2ccs_seq (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
        .controller_enable(en), .ten_bit_select(ten), .receive_byte_count(cnt),
        .scl_high_count(8'h03), .scl_low_count(8'h04), .start_set(ss), .restart_set(rs),
        .stop_set(ps), .start_req_r(start_r), .restart_req_r(restart_r), .stop_req_r(stop_r),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready_r(tx_ready), .rx_data_r(rx_data),
        .rx_valid_r(rx_valid), .addr_ack_clr(ac), .done_clr(dc), .addr_ack_flag_r(aflag),
        .done_flag_r(dflag), .scl_in(scl), .scl_o_r(scl_o), .scl_oe_n_r(scl_oe_n), .sda_in(sda),
        .sda_o_r(sda_o), .sda_oe_n_r(sda_oe_n));
    i2ccs_target u_i2ccs_target (.scl(scl), .sda(sda), .sda_oe_n(t_oe_n));
    always @(posedge sys_clk) begin
        cyc++;
        if (rx_valid === 1'b1) nrx++;
        if (cyc == 40000) begin failures++; test_done(); end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic step;
        @(posedge sys_clk);
        #1;
    endtask : step
    task automatic req(input logic [4:0] m);
        {ss, rs, ps, ac, dc} = m;
        step();
        {ss, rs, ps, ac, dc} = 5'h00;
        step();
    endtask : req
    task automatic push(input logic [7:0] b);
        tx_valid = 1'b1;
        tx_data = b;
        do @(posedge sys_clk); while (tx_ready !== 1'b1);
        #1 tx_valid = 1'b0;
        step();
    endtask : push
    task automatic t_disable;
        req(5'h1C);
        chk({5'h00, start_r, restart_r, stop_r}, 8'h00);
        chk({6'h00, scl_o, sda_o}, 8'h00);
        en = 1'b1;
    endtask : t_disable
    task automatic t_write;
        push(8'hA4);
        req(5'h10);
        push(8'h3C);
        wait (u_i2ccs_target.nbytes == 8'h01);
        chk(u_i2ccs_target.got, 8'hA4);
        wait (u_i2ccs_target.nbytes == 8'h02);
        repeat (400) step();
        chk({5'h00, start_r, scl, u_i2ccs_target.stops[0]}, 8'h04);
        push(8'hC3);
        req(5'h04);
        wait (start_r === 1'b0);
        chk(u_i2ccs_target.got, 8'hC3);
        chk({aflag, dflag, u_i2ccs_target.nbytes[5:0]}, 8'hC3);
    endtask : t_write
    task automatic t_read;
        int n0;
        n0 = nrx;
        step();
        cnt = 8'h02;
        req(5'h03);
        chk({6'h00, aflag, dflag}, 8'h00);
        push(8'hA5);
        req(5'h14);
        wait (start_r === 1'b0);
        chk(rx_data, 8'h96);
        chk({aflag, dflag, 6'(nrx - n0)}, 8'hC2);
        chk(u_i2ccs_target.stops, 8'h02);
    endtask : t_read
    task automatic t_ten;
        int n0;
        n0 = nrx;
        step();
        ten = 1'b1;
        cnt = 8'h01;
        push(8'hF0);
        req(5'h1C);
        push(8'h5A);
        wait (restart_r === 1'b0);
        step();
        chk({5'h00, start_r, restart_r, stop_r}, 8'h04);
        chk(u_i2ccs_target.got, 8'h5A);
        push(8'hF1);
        wait (nrx == n0 + 1);
        step();
        req(5'h04);
        wait (start_r === 1'b0);
        chk(rx_data, 8'h96);
        chk({u_i2ccs_target.starts[3:0], u_i2ccs_target.stops[3:0]}, 8'h43);
    endtask : t_ten
    task automatic test_done;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    initial begin
        repeat (6) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (4) step();
        t_disable();
        t_write();
        t_read();
        t_ten();
        test_done();
    end
endmodule : i2ccs_seq_test
`default_nettype wire
